// ---- hw/vdt_pkg.sv ----
// constants and types shared by the vlan / priority-map table access logic
package vdt_pkg;
    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [13:0] IDX_VLAN_STS  = 14'h1810;
    localparam logic [13:0] IDX_PM_CMD    = 14'h1811;
    localparam logic [13:0] IDX_PM_WDATA  = 14'h1812;
    localparam logic [13:0] IDX_PM_RDATA  = 14'h1813;
    localparam logic [13:0] IDX_PM_STS    = 14'h1814;
    localparam logic [13:0] IDX_VLAN_DATA = 14'h1818;
    localparam logic [13:0] IDX_VLAN_CMD  = 14'h1819;
    // ------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------
    localparam int          PEND_BIT      = 0;
    localparam int          DIR_BIT       = 7;
    localparam int          PM_IDX_W      = 6;
    localparam int          PRIO_W        = 3;
    localparam int          VID_W         = 12;
    localparam int          UNTAG0_BIT    = 12;
    localparam int          ENTRY_W       = 18;
    localparam int          PORTS         = 3;
    localparam int          VLAN_ENTRIES  = 16;
    localparam int          VLAN_IDX_W    = 4;
    localparam int          PM_ENTRIES    = 64;
    localparam logic [11:0] VID_NULL      = 12'h000;
    localparam logic        DIR_READ      = 1'h1;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  CMD_RST       = 8'h00;
    localparam logic [2:0]  PRIO_RST      = 3'h0;

    typedef enum logic [2:0] {
        SEL_NONE, SEL_VLAN_STS, SEL_PM_CMD, SEL_PM_WDATA,
        SEL_PM_RDATA, SEL_PM_STS, SEL_VLAN_DATA, SEL_VLAN_CMD
    } vdt_sel_t;
endpackage : vdt_pkg

// ---- hw/vdt_tbl_if.sv ----
// link between the register front end and the priority-map table
`timescale 1ns/1ps
interface vdt_tbl_if;
    logic       req;
    logic       dir;
    logic [5:0] index;
    logic [2:0] wdata;
    logic       done;
    logic [2:0] rdata;
    logic       lk_valid;
    logic [5:0] lk_tos;
    logic [2:0] lk_prio;
    modport ctl (output req, dir, index, wdata, lk_valid, lk_tos, input done, rdata, lk_prio);
    modport tbl (input req, dir, index, wdata, lk_valid, lk_tos, output done, rdata, lk_prio);
endinterface : vdt_tbl_if

// ---- hw/vdt_prio_table.sv ----
// 64-entry tos/cs to receive-priority table with one access and one lookup port
`timescale 1ns/1ps
module vdt_prio_table (
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    vdt_tbl_if.tbl    tb
);
    typedef struct packed {
        logic       done;
        logic [2:0] rdata;
        logic [2:0] lk_prio;
    } vdt_tbl_st_t;

    vdt_tbl_st_t q, d;
    // contents are left uninitialised at reset, software must fill them
    logic [2:0]  mem [vdt_pkg::PM_ENTRIES];

    always_comb begin
        d         = q;
        d.done    = tb.req;
        if (tb.lk_valid) begin
            d.lk_prio = mem[tb.lk_tos];                        // [RL10]
        end
        if (tb.req && tb.dir == vdt_pkg::DIR_READ) begin
            d.rdata = mem[tb.index];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
        if (tb.req && tb.dir != vdt_pkg::DIR_READ) begin
            mem[tb.index] <= tb.wdata;                         // [RL12] [RL15]
        end
    end

    assign tb.done    = q.done;
    assign tb.rdata   = q.rdata;
    assign tb.lk_prio = q.lk_prio;

    tbl_store_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RL12]
        tb.req && !tb.dir |=> mem[$past(tb.index)] == $past(tb.wdata))
        else $error("table write not stored");
    tbl_done_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RL7]
        tb.req |=> tb.done ##1 !tb.done)
        else $error("table access did not finish in one cycle");
endmodule : vdt_prio_table

// ---- hw/vdt_access.sv ----
// vlan table and priority-map table register access over avalon-mm
//
// Functional notes
// RL1 - entry low 12 bits hold the vlan identifier
// RL2 - identifier zero disables an entry
// RL3 - software never programs the reserved identifier
// RL4 - bit 12 is the port 0 untag flag
// RL5 - vlan status bit 0 pends, self-clears
// RL6 - vlan status reports outstanding vlan command only
// RL7 - command register write launches one table access
// RL8 - direction bit 7: one read, zero write
// RL9 - six-bit index selects one of 64 entries
// RL10 - table maps received tos/cs to priority
// RL11 - read: command, poll pending, fetch read data
// RL12 - write: load data, command, poll pending
// RL13 - write-data low 3 bits hold priority
// RL14 - read-data shows last read entry priority
// RL15 - table contents not initialised at reset
// RL16 - member flag admits ingress, joins egress domain
// RL17 - untag flag strips tag on hybrid egress
// RL18 - separate status register with self-clearing pending
// RL19 - no new command while pending; the code still accepts a command written while pending and launches it
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module vdt_access (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic [15:0] i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_pkt_valid,
    input  wire logic [11:0] i_pkt_vid,
    input  wire logic [5:0]  i_pkt_tos,
    input  wire logic [2:0]  i_hybrid_port,
    output logic             o_lookup_valid,
    output logic             o_vlan_hit,
    output logic      [2:0]  o_vlan_member,
    output logic      [2:0]  o_vlan_untag,
    output logic      [2:0]  o_strip_tag,
    output logic      [2:0]  o_rx_priority
);
    // ------------------------------------------------------------
    // types and state
    // ------------------------------------------------------------
    typedef enum logic {BP_IDLE, BP_ANSWER} vdt_phase_t;

    typedef struct packed {
        vdt_phase_t  phase;
        logic        waitreq;
        logic [31:0] rdata;
        logic        pm_dir;
        logic [5:0]  pm_idx;
        logic [2:0]  pm_wdata;
        logic [2:0]  pm_rd;
        logic        pm_pend;
        logic        pm_req;
        logic        vl_dir;
        logic [3:0]  vl_idx;
        logic [17:0] vl_data;
        logic        vl_pend;
        logic        lk_valid;
        logic        hit;
        logic [2:0]  member;
        logic [2:0]  untag;
        logic [2:0]  strip;
    } vdt_state_t;

    localparam vdt_state_t ST_RST = '{
        phase: BP_IDLE, waitreq: 1'h1, rdata: 32'h0, pm_dir: vdt_pkg::CMD_RST[7],
        pm_idx: vdt_pkg::CMD_RST[5:0], pm_wdata: vdt_pkg::PRIO_RST,
        pm_rd: vdt_pkg::PRIO_RST, default: '0};

    vdt_state_t  q, d;
    logic [17:0] vlan_mem [vdt_pkg::VLAN_ENTRIES];
    vdt_tbl_if   tbl ();
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic vdt_pkg::vdt_sel_t reg_sel(input logic [15:0] a);
        vdt_pkg::vdt_sel_t s;
        s = vdt_pkg::SEL_NONE;
        if (a[1:0] == 2'h0) begin
            case (a[15:2])
                vdt_pkg::IDX_VLAN_STS:  s = vdt_pkg::SEL_VLAN_STS;
                vdt_pkg::IDX_PM_CMD:    s = vdt_pkg::SEL_PM_CMD;
                vdt_pkg::IDX_PM_WDATA:  s = vdt_pkg::SEL_PM_WDATA;
                vdt_pkg::IDX_PM_RDATA:  s = vdt_pkg::SEL_PM_RDATA;
                vdt_pkg::IDX_PM_STS:    s = vdt_pkg::SEL_PM_STS;
                vdt_pkg::IDX_VLAN_DATA: s = vdt_pkg::SEL_VLAN_DATA;
                vdt_pkg::IDX_VLAN_CMD:  s = vdt_pkg::SEL_VLAN_CMD;
                default:                s = vdt_pkg::SEL_NONE;
            endcase
        end
        return s;
    endfunction : reg_sel

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        vdt_pkg::vdt_sel_t sel;
        logic [31:0]       word;
        logic              found;
        sel   = reg_sel(i_avs_address);
        word  = 32'h0;
        found = 1'b0;
        d     = q;
        d.pm_req = 1'b0;

        // readback, reserved bits read as zero
        case (sel)
            vdt_pkg::SEL_VLAN_STS:  word[vdt_pkg::PEND_BIT] = q.vl_pend;   // [RL5] [RL6]
            vdt_pkg::SEL_PM_CMD:    word[7:0] = {q.pm_dir, 1'b0, q.pm_idx};
            vdt_pkg::SEL_PM_WDATA:  word[2:0] = q.pm_wdata;
            vdt_pkg::SEL_PM_RDATA:  word[2:0] = q.pm_rd;                   // [RL14]
            vdt_pkg::SEL_PM_STS:    word[vdt_pkg::PEND_BIT] = q.pm_pend;   // [RL18]
            vdt_pkg::SEL_VLAN_DATA: word[17:0] = q.vl_data;
            vdt_pkg::SEL_VLAN_CMD:  word[7:0] = {q.vl_dir, 3'h0, q.vl_idx};
            default:                word = 32'h0;
        endcase

        // completions first so that a new launch in the same cycle wins
        if (tbl.done) begin
            d.pm_pend = 1'b0;                                            // [RL11] [RL12]
            if (q.pm_dir == vdt_pkg::DIR_READ) begin
                d.pm_rd = tbl.rdata;                                     // [RL14]
            end
        end
        if (q.vl_pend) begin
            d.vl_pend = 1'b0;                                            // [RL5]
            if (q.vl_dir == vdt_pkg::DIR_READ) begin
                d.vl_data = vlan_mem[q.vl_idx];
            end
        end

        // one wait cycle, then the answer stands for exactly one edge
        case (q.phase)
            BP_IDLE: begin
                if (i_avs_read || i_avs_write) begin
                    d.phase   = BP_ANSWER;
                    d.waitreq = 1'b0;
                    d.rdata   = i_avs_read ? word : 32'h0;
                end
            end
            BP_ANSWER: begin
                d.phase   = BP_IDLE;
                d.waitreq = 1'b1;
                if (i_avs_write) begin
                    case (sel)
                        vdt_pkg::SEL_PM_CMD: begin
                            d.pm_dir  = i_avs_writedata[vdt_pkg::DIR_BIT];   // [RL8]
                            d.pm_idx  = i_avs_writedata[5:0];                // [RL9]
                            d.pm_pend = 1'b1;                                // [RL7]
                            d.pm_req  = 1'b1;
                        end
                        vdt_pkg::SEL_PM_WDATA: d.pm_wdata = i_avs_writedata[2:0]; // [RL13]
                        vdt_pkg::SEL_VLAN_DATA: d.vl_data = i_avs_writedata[17:0];
                        vdt_pkg::SEL_VLAN_CMD: begin
                            d.vl_dir  = i_avs_writedata[vdt_pkg::DIR_BIT];
                            d.vl_idx  = i_avs_writedata[3:0];
                            d.vl_pend = 1'b1;                                // [RL5]
                        end
                        default: d.vl_pend = d.vl_pend;
                    endcase
                end
            end
            default: begin
                d.phase   = BP_IDLE;
                d.waitreq = 1'b1;
            end
        endcase

        // vlan lookup, lowest matching entry wins
        d.lk_valid = i_pkt_valid;
        d.hit      = 1'b0;
        d.member   = 3'h0;
        d.untag    = 3'h0;
        if (i_pkt_valid && i_pkt_vid != vdt_pkg::VID_NULL) begin              // [RL2]
            for (int e = 0; e < vdt_pkg::VLAN_ENTRIES; e++) begin
                if (!found && vlan_mem[e][vdt_pkg::VID_W-1:0] == i_pkt_vid) begin // [RL1]
                    found = 1'b1;
                    for (int p = 0; p < vdt_pkg::PORTS; p++) begin
                        d.untag[p]  = vlan_mem[e][vdt_pkg::UNTAG0_BIT + 2*p];   // [RL4]
                        d.member[p] = vlan_mem[e][vdt_pkg::UNTAG0_BIT + 2*p + 1]; // [RL16]
                    end
                end
            end
        end
        d.hit   = found;
        d.strip = d.untag & i_hybrid_port;                                   // [RL17]
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
        // vlan entries have no reset; software programs them
        if (!i_rst && q.vl_pend && q.vl_dir != vdt_pkg::DIR_READ) begin
            vlan_mem[q.vl_idx] <= q.vl_data;
        end
    end

    // ------------------------------------------------------------
    // priority-map table
    // ------------------------------------------------------------
    assign tbl.req      = q.pm_req;
    assign tbl.dir      = q.pm_dir;
    assign tbl.index    = q.pm_idx;
    assign tbl.wdata    = q.pm_wdata;
    assign tbl.lk_valid = i_pkt_valid;
    assign tbl.lk_tos   = i_pkt_tos;

    vdt_prio_table u_table (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .tb        (tbl.tbl)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_avs_readdata    = q.rdata;
    assign o_avs_waitrequest = q.waitreq;
    assign o_lookup_valid    = q.lk_valid;
    assign o_vlan_hit        = q.hit;
    assign o_vlan_member     = q.member;
    assign o_vlan_untag      = q.untag;
    assign o_strip_tag       = q.strip;
    assign o_rx_priority     = tbl.lk_prio;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // a command is taken at the edge that ends the answer cycle, as a write lands
    logic cmd_taken;
    logic vcmd_taken;
    logic rd_taken;
    logic wr_taken;
    logic pm_load;
    assign rd_taken   = q.phase == BP_IDLE && i_avs_read;
    assign wr_taken   = q.phase == BP_IDLE && i_avs_write;
    assign pm_load    = tbl.done && q.pm_dir == vdt_pkg::DIR_READ;
    assign cmd_taken  = q.phase == BP_ANSWER && i_avs_write
                        && reg_sel(i_avs_address) == vdt_pkg::SEL_PM_CMD;
    assign vcmd_taken = q.phase == BP_ANSWER && i_avs_write
                        && reg_sel(i_avs_address) == vdt_pkg::SEL_VLAN_CMD;

    pm_pend_window_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RL7]
        cmd_taken |=> q.pm_pend [*2] ##1 !q.pm_pend)
        else $error("priority-map pending not two cycles");
    pm_dir_idx_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RL9]
        cmd_taken |=> q.pm_idx == $past(i_avs_writedata[5:0])
                      && q.pm_dir == $past(i_avs_writedata[7]))
        else $error("command fields not captured");
    pm_read_data_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RL14]
        tbl.done && q.pm_dir |=> q.pm_rd == $past(tbl.rdata))
        else $error("read data not taken from table");
    pm_wdata_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RL13]
        !(q.phase == BP_ANSWER && i_avs_write) |=> $stable(q.pm_wdata))
        else $error("write data changed without a bus write");
    vlan_pend_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RL5]
        vcmd_taken |=> q.vl_pend ##1 !q.vl_pend)
        else $error("vlan pending not one cycle");
    bus_answer_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest
        ##1 o_avs_waitrequest)
        else $error("waitrequest not low for exactly one cycle");
    sts_reserved_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RL6]
        q.phase == BP_IDLE && i_avs_read
        && reg_sel(i_avs_address) inside {vdt_pkg::SEL_VLAN_STS, vdt_pkg::SEL_PM_STS}
        |=> o_avs_readdata[31:1] == 31'h0)
        else $error("status reserved bits not zero");
    null_vid_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RL2]
        o_vlan_hit |-> $past(i_pkt_vid) != vdt_pkg::VID_NULL)
        else $error("null identifier matched an entry");
    strip_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [RL17]
        o_lookup_valid |-> o_strip_tag == (o_vlan_untag & $past(i_hybrid_port)))
        else $error("tag strip not gated by hybrid port");
    unmapped_zero_a: assert property (
        rd_taken && reg_sel(i_avs_address) == vdt_pkg::SEL_NONE
        |=> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    write_rdata_a: assert property (
        wr_taken |=> o_avs_readdata == 32'h0)
        else $error("read data not zero on a write answer");
    cmd_reserved_a: assert property ( // [RL8]
        rd_taken && reg_sel(i_avs_address) == vdt_pkg::SEL_PM_CMD
        |=> o_avs_readdata[31:8] == 24'h0 && !o_avs_readdata[6])
        else $error("command reserved bits not zero");
    vlan_sts_a: assert property ( // [RL5]
        rd_taken && reg_sel(i_avs_address) == vdt_pkg::SEL_VLAN_STS
        |=> o_avs_readdata[0] == $past(q.vl_pend))
        else $error("vlan pending not reported");
    pm_sts_a: assert property ( // [RL18]
        rd_taken && reg_sel(i_avs_address) == vdt_pkg::SEL_PM_STS
        |=> o_avs_readdata[0] == $past(q.pm_pend))
        else $error("table pending not reported");
    pm_rd_hold_a: assert property ( // [RL14]
        !pm_load |=> $stable(q.pm_rd))
        else $error("read data changed without a table read");
    pm_req_pulse_a: assert property ( // [RL7]
        q.pm_req |=> !q.pm_req && q.pm_pend)
        else $error("table request not a single pulse");
    vlan_store_a: assert property ( // [RL4]
        q.vl_pend && q.vl_dir != vdt_pkg::DIR_READ
        |=> vlan_mem[$past(q.vl_idx)] == $past(q.vl_data))
        else $error("vlan entry not stored");
    miss_clear_a: assert property ( // [RL16]
        !o_vlan_hit |-> o_vlan_member == 3'h0 && o_vlan_untag == 3'h0)
        else $error("flags shown without a matching entry");
    lookup_pulse_a: assert property ( // [RL1]
        i_pkt_valid |=> o_lookup_valid)
        else $error("lookup answer not one cycle later");
    rdata_stand_a: assert property (
        !o_avs_waitrequest |=> $stable(o_avs_readdata))
        else $error("read data did not stand after the answer");
    wdata_land_a: assert property ( // [RL13]
        q.phase == BP_ANSWER && i_avs_write
        && reg_sel(i_avs_address) == vdt_pkg::SEL_PM_WDATA
        |=> q.pm_wdata == $past(i_avs_writedata[2:0]))
        else $error("write data not stored");

    pm_read_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        cmd_taken && i_avs_writedata[7] ##3 !q.pm_pend);
    pm_write_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        cmd_taken && !i_avs_writedata[7]);
    vlan_hit_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        o_vlan_hit && o_strip_tag != 3'h0);
    bus_b2b_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        !o_avs_waitrequest ##3 !o_avs_waitrequest);
    vlan_read_c: cover property (vcmd_taken && i_avs_writedata[7] ##2 !q.vl_pend);
endmodule : vdt_access

// ---- verif/test_vlan_diffserv_table_access.sv ----
// register-level testbench for the vlan / priority-map table access block
`timescale 1ns/1ps
module test_vlan_diffserv_table_access;
    logic        i_ref_clk;
    logic        i_rst;
    logic [15:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest;
    logic        pkt_valid;
    logic [11:0] pkt_vid;
    logic [5:0]  pkt_tos;
    logic [2:0]  hybrid_port;
    logic        o_lookup_valid;
    logic        o_vlan_hit;
    logic [2:0]  o_vlan_member;
    logic [2:0]  o_vlan_untag;
    logic [2:0]  o_strip_tag;
    logic [2:0]  o_rx_priority;
    logic [31:0] rd;
    int          n_mismatch;
    int          n_checks;

    vdt_access dut_u (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_address(avs_address),
        .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_pkt_valid(pkt_valid), .i_pkt_vid(pkt_vid), .i_pkt_tos(pkt_tos),
        .i_hybrid_port(hybrid_port), .o_lookup_valid(o_lookup_valid),
        .o_vlan_hit(o_vlan_hit), .o_vlan_member(o_vlan_member),
        .o_vlan_untag(o_vlan_untag), .o_strip_tag(o_strip_tag),
        .o_rx_priority(o_rx_priority)
    );

    always #2.5 i_ref_clk = ~i_ref_clk;

    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    function automatic logic [2:0] prio_of(input int i);
        return 3'((i * 5 + 3) % 8);
    endfunction : prio_of

    // entry 0 carries flags but a null identifier; entries 1 and 2 share an identifier
    function automatic logic [17:0] ventry(input int e);
        if (e == 0) return {6'h3F, 12'h000};
        if (e == 1) return {6'h03, 12'h005};
        if (e == 2) return {6'h3F, 12'h005};
        return {6'(e * 3), 12'h200 + 12'(e)};
    endfunction : ventry

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // holds the request until waitrequest is sampled low, takes data at that edge
    task automatic bus(input logic wr, input logic [13:0] idx, input logic [31:0] data,
                       input logic [1:0] lo = 2'h0);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        avs_address <= {idx, lo};
        avs_writedata <= data;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 100);
        rd = o_avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 100) chk("bus answer", 32'h0, 32'h1);
    endtask : bus

    task automatic poll(input logic [13:0] idx);
        int n;
        n = 0;
        do begin
            bus(1'b0, idx, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 20);
        chk("pending clears", 32'h0, rd);
    endtask : poll

    task automatic lookup(input logic [11:0] vlan_identifier, input logic [2:0] hyb, input int e);
        logic [17:0] d;
        d = (e < 0) ? 18'h0 : ventry(e);
        @(posedge i_ref_clk);
        pkt_valid <= 1'b1;
        pkt_vid <= vlan_identifier;
        hybrid_port <= hyb;
        @(posedge i_ref_clk);
        pkt_valid <= 1'b0;
        @(negedge i_ref_clk);
        chk("lookup valid", 32'h1, 32'(o_lookup_valid));
        chk("vlan hit", 32'(e >= 0), 32'(o_vlan_hit));
        chk("vlan member", 32'({d[17], d[15], d[13]}), 32'(o_vlan_member));
        chk("vlan untag", 32'({d[16], d[14], d[12]}), 32'(o_vlan_untag));
        chk("strip tag", 32'({d[16], d[14], d[12]} & hyb), 32'(o_strip_tag));
    endtask : lookup

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge i_ref_clk);
        n_mismatch++;
        summarize();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        i_rst = 1'b1;
        avs_address = 16'h0000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        pkt_valid = 1'b0;
        pkt_vid = 12'h000;
        pkt_tos = 6'h00;
        hybrid_port = 3'h0;
        n_mismatch = 0;
        n_checks = 0;
        repeat (20) @(posedge i_ref_clk);
        i_rst <= 1'b0;

        bus(1'b0, vdt_pkg::IDX_VLAN_STS, 32'h0);
        chk("vlan status reset", 32'h0, rd);
        bus(1'b0, vdt_pkg::IDX_PM_CMD, 32'h0);
        chk("command reset", 32'h0, rd);
        bus(1'b0, vdt_pkg::IDX_PM_WDATA, 32'h0);
        chk("write data reset", 32'h0, rd);
        bus(1'b0, vdt_pkg::IDX_PM_RDATA, 32'h0);
        chk("read data reset", 32'h0, rd);
        bus(1'b0, vdt_pkg::IDX_PM_STS, 32'h0);
        chk("table status reset", 32'h0, rd);
        bus(1'b0, 14'h1820, 32'h0);
        chk("unmapped read", 32'h0, rd);
        $display("test reset values done");

        bus(1'b1, vdt_pkg::IDX_PM_WDATA, 32'hFFFFFFFF);
        bus(1'b0, vdt_pkg::IDX_PM_WDATA, 32'h0);
        chk("write data mask", 32'h7, rd);
        bus(1'b1, vdt_pkg::IDX_PM_WDATA, 32'h0, 2'h1);
        bus(1'b0, vdt_pkg::IDX_PM_WDATA, 32'h0);
        chk("misaligned write ignored", 32'h7, rd);
        bus(1'b1, vdt_pkg::IDX_PM_RDATA, 32'h5);
        bus(1'b0, vdt_pkg::IDX_PM_RDATA, 32'h0);
        chk("read data is read-only", 32'h0, rd);
        bus(1'b1, vdt_pkg::IDX_PM_STS, 32'h1);
        bus(1'b0, vdt_pkg::IDX_PM_STS, 32'h0);
        chk("status is read-only", 32'h0, rd);
        $display("test register access done");

        // every entry written before any lookup is trusted
        for (int i = 0; i < 64; i++) begin
            bus(1'b1, vdt_pkg::IDX_PM_WDATA, 32'(prio_of(i)));
            bus(1'b1, vdt_pkg::IDX_PM_CMD, 32'(i));
            poll(vdt_pkg::IDX_PM_STS);
        end
        for (int i = 62; i >= 0; i--) begin
            bus(1'b1, vdt_pkg::IDX_PM_CMD, 32'h80 | 32'(i));
            poll(vdt_pkg::IDX_PM_STS);
            bus(1'b0, vdt_pkg::IDX_PM_RDATA, 32'h0);
            chk("table read back", 32'(prio_of(i)), rd);
        end
        bus(1'b1, vdt_pkg::IDX_PM_CMD, 32'hFFFFFFFF);
        poll(vdt_pkg::IDX_PM_STS);
        bus(1'b0, vdt_pkg::IDX_PM_CMD, 32'h0);
        chk("command readback", 32'hBF, rd);
        bus(1'b0, vdt_pkg::IDX_PM_RDATA, 32'h0);
        chk("read of top entry", 32'(prio_of(63)), rd);
        $display("test priority table access done");

        // back-to-back lookups, one tos/cs value each cycle
        for (int t = 0; t <= 64; t++) begin
            @(posedge i_ref_clk);
            pkt_valid <= (t < 64);
            pkt_tos <= 6'(t);
            @(negedge i_ref_clk);
            if (t > 0) chk("rx priority", 32'(prio_of(t - 1)), 32'(o_rx_priority));
        end
        $display("test priority lookup done");

        for (int e = 0; e < vdt_pkg::VLAN_ENTRIES; e++) begin
            bus(1'b1, vdt_pkg::IDX_VLAN_DATA, 32'(ventry(e)));
            bus(1'b1, vdt_pkg::IDX_VLAN_CMD, 32'(e));
            poll(vdt_pkg::IDX_VLAN_STS);
        end
        for (int e = 0; e < vdt_pkg::VLAN_ENTRIES; e += 5) begin
            bus(1'b1, vdt_pkg::IDX_VLAN_DATA, 32'h0);
            bus(1'b1, vdt_pkg::IDX_VLAN_CMD, 32'h80 | 32'(e));
            poll(vdt_pkg::IDX_VLAN_STS);
            bus(1'b0, vdt_pkg::IDX_VLAN_DATA, 32'h0);
            chk("vlan entry read back", 32'(ventry(e)), rd);
        end
        lookup(12'h000, 3'h7, -1);
        lookup(12'h005, 3'h1, 1);
        lookup(12'h005, 3'h0, 1);
        lookup(12'h20A, 3'h7, 10);
        lookup(12'h20F, 3'h5, 15);
        lookup(12'h30A, 3'h7, -1);
        $display("test vlan lookup done");
        summarize();
    end
endmodule : test_vlan_diffserv_table_access
